// [src/nvm_cfg.svh]
// constants for the data nonvolatile memory access controller
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH
`define NVM_DEPTH 64
`define NVM_AW 6
`define NVM_DW 8
`define CTRL_BANK 8'h01
`define CTRL_OFFSET 8'h40
`define CTRL_PROG_PERMIT 3
`define CTRL_PROG_GO 2
`define CTRL_FETCH_PERMIT 1
`define CTRL_FETCH_GO 0
`define RESET_BYTE 8'h00
`define FETCH_CYCLES 4'h4
`define PROG_TIME_NS 2000
`define PROG_CYCLES (`PROG_TIME_NS / 10)
`define PROG_TIMER_DIV 8'h07
`endif

// [src/nvm_pkg.sv]
// types for the data nonvolatile memory access controller
package nvm_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_fetch = 2'b01,
    st_prog = 2'b11,
    st_done = 2'b10
  } nvm_state_e;
  typedef enum logic [1:0] {
    sel_none = 2'b00,
    sel_index = 2'b01,
    sel_value = 2'b10,
    sel_ctrl = 2'b11
  } reg_sel_e;
endpackage

// [src/nvm_cell_array.sv]
// storage cells of the data nonvolatile memory
`timescale 1ns/10ps
`default_nettype none
`include "nvm_cfg.svh"
module nvm_cell_array (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [`NVM_AW-1:0] addr,
  input wire logic [`NVM_DW-1:0] wdata,
  output logic [`NVM_DW-1:0] rdata
);
  logic [`NVM_DW-1:0] cells [0:`NVM_DEPTH-1];
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end
endmodule // nvm_cell_array
`default_nettype wire

// [src/nvm_prog_timer.sv]
// free-running program timer, its ticks are unrelated to instruction flow
`timescale 1ns/10ps
`default_nettype none
`include "nvm_cfg.svh"
module nvm_prog_timer #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [7:0] div_q;
  logic [15:0] cnt_q;
  logic tick;
  logic [15:0] ticks_needed;
  assign tick = (div_q == `PROG_TIMER_DIV);
  assign ticks_needed = 16'(PROG_CYCLES / 8);
  assign busy = (cnt_q != 16'h0000);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 8'h00;
      cnt_q <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_q <= (ticks_needed == 16'h0000) ? 16'h0001 : ticks_needed;
      end
      else if (busy && tick)
      begin
        cnt_q <= cnt_q - 16'h0001;
        done <= (cnt_q == 16'h0001);
      end
    end
  end
endmodule // nvm_prog_timer
`default_nettype wire

// [src/data_eeprom_access_ctrl.sv]
// register-driven controller for the 64-byte data nonvolatile memory
`timescale 1ns/10ps
`default_nettype none
`include "nvm_cfg.svh"
module data_eeprom_access_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire nvm_pkg::reg_sel_e reg_sel,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] pointer_bank_byte,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic nvm_irq_enable,
  input wire logic mf_irq_enable,
  input wire logic global_irq_enable,
  input wire logic nvm_irq_flag_clr,
  input wire logic mf_irq_service,
  output logic nvm_irq_flag,
  output logic mf_irq_flag,
  output logic irq_req
);
  import nvm_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  nvm_state_e state_q, state_d;
  logic [`NVM_AW-1:0] index_q;
  logic [`NVM_DW-1:0] value_q;
  logic [3:0] ctrl_q;
  logic [3:0] fetch_cnt_q;
  logic ctrl_hit, wr_index, wr_value, wr_ctrl;
  logic prog_start, fetch_start, prog_busy, prog_done, fetch_done;
  logic [`NVM_DW-1:0] cell_rdata;
  logic [3:0] ctrl_wr_d;
  logic [3:0] fetch_cnt_d;
  logic in_idle;
  logic in_fetch;
  logic rd_pick_index;
  logic rd_pick_value;
  logic [7:0] rd_index_byte;
  logic [7:0] rd_value_byte;
  logic [7:0] rd_ctrl_byte;

  // ------------------------------------------------------------
  // control address match
  // ------------------------------------------------------------
  function automatic logic ctrl_reachable(input logic [7:0] lo,
                                          input logic [7:0] bank);
    ctrl_reachable = (lo == `CTRL_OFFSET) && (bank == `CTRL_BANK);
  endfunction

  // ------------------------------------------------------------
  // state decode
  // ------------------------------------------------------------
  assign in_idle = (state_q == st_idle);
  assign in_fetch = (state_q == st_fetch);
  assign fetch_cnt_d = in_fetch ? fetch_cnt_q + 4'h1 : 4'h0;

  // bank byte resets to zero outside, so the control is hidden by default
  assign ctrl_hit = (reg_sel == sel_ctrl) &&
                    ctrl_reachable(pointer_low_byte, pointer_bank_byte);

  // ------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------
  assign wr_index = reg_wr && (reg_sel == sel_index);
  assign wr_value = reg_wr && (reg_sel == sel_value);
  assign wr_ctrl = reg_wr && ctrl_hit;

  // ------------------------------------------------------------
  // launch gating
  // ------------------------------------------------------------
  // go bits only take a one when their permit was already set
  assign prog_start = wr_ctrl && reg_wdata[`CTRL_PROG_GO] &&
                      ctrl_q[`CTRL_PROG_PERMIT] && !ctrl_q[`CTRL_PROG_GO] &&
                      !ctrl_q[`CTRL_FETCH_GO] && in_idle &&
                      !prog_busy;
  assign fetch_start = wr_ctrl && reg_wdata[`CTRL_FETCH_GO] &&
                       ctrl_q[`CTRL_FETCH_PERMIT] && !ctrl_q[`CTRL_FETCH_GO] &&
                       !prog_start && in_idle;
  assign fetch_done = in_fetch &&
                      (fetch_cnt_q == `FETCH_CYCLES);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  assign rd_pick_index = (reg_sel == sel_index);
  assign rd_pick_value = (reg_sel == sel_value);
  assign rd_index_byte = {2'b00, index_q};
  assign rd_value_byte = value_q;
  assign rd_ctrl_byte = {4'h0, ctrl_q};
  assign reg_rdata = rd_pick_index ? rd_index_byte :
                     rd_pick_value ? rd_value_byte :
                     ctrl_hit ? rd_ctrl_byte : `RESET_BYTE;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    case (state_q)
      st_idle:
        state_d = prog_start ? st_prog : (fetch_start ? st_fetch : st_idle);
      st_fetch: state_d = fetch_done ? st_done : st_fetch;
      st_prog: state_d = prog_done ? st_done : st_prog;
      st_done: state_d = st_idle;
      default: state_d = st_idle;
    endcase
  end

  // ------------------------------------------------------------
  // next control value: permits from software, go bits set or cleared
  // ------------------------------------------------------------
  always_comb
  begin
    ctrl_wr_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_wr_d[`CTRL_PROG_PERMIT] = reg_wdata[`CTRL_PROG_PERMIT];
      ctrl_wr_d[`CTRL_FETCH_PERMIT] = reg_wdata[`CTRL_FETCH_PERMIT];
    end
    if (prog_start)
    begin
      ctrl_wr_d[`CTRL_PROG_GO] = 1'b1;
    end
    if (fetch_start)
    begin
      ctrl_wr_d[`CTRL_FETCH_GO] = 1'b1;
    end
    if (prog_done)
    begin
      ctrl_wr_d[`CTRL_PROG_GO] = 1'b0;
    end
    if (fetch_done)
    begin
      ctrl_wr_d[`CTRL_FETCH_GO] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= 4'h0;
    end
    else
    begin
      ctrl_q <= ctrl_wr_d;
    end
  end

  // ------------------------------------------------------------
  // fetch counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fetch_cnt_q <= 4'h0;
    end
    else
    begin
      fetch_cnt_q <= fetch_cnt_d;
    end
  end

  // ------------------------------------------------------------
  // index register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      index_q <= 6'h00;
    end
    else if (wr_index)
    begin
      index_q <= reg_wdata[`NVM_AW-1:0];
    end
  end

  // ------------------------------------------------------------
  // value register: fetched byte lands as fetch_go clears, then holds
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      value_q <= 8'h00;
    end
    else if (fetch_done)
    begin
      value_q <= cell_rdata;
    end
    else if (wr_value)
    begin
      value_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // completion flags
  // ------------------------------------------------------------
  // hardware set wins over clear in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      nvm_irq_flag <= 1'b0;
    end
    else
    begin
      nvm_irq_flag <= prog_done | (nvm_irq_flag & ~nvm_irq_flag_clr);
    end
  end

  // ------------------------------------------------------------
  // multi-function flag, cleared by servicing only
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mf_irq_flag <= 1'b0;
    end
    else
    begin
      mf_irq_flag <= prog_done | (mf_irq_flag & ~mf_irq_service);
    end
  end

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  assign irq_req = mf_irq_flag && nvm_irq_flag && nvm_irq_enable &&
                   mf_irq_enable && global_irq_enable;

  // ------------------------------------------------------------
  // storage cells
  // ------------------------------------------------------------
  nvm_cell_array u_cells (
    .core_clk(core_clk),
    .wr_en(prog_start),
    .addr(index_q),
    .wdata(value_q),
    .rdata(cell_rdata)
  );

  // ------------------------------------------------------------
  // program timer
  // ------------------------------------------------------------
  nvm_prog_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(prog_start),
    .busy(prog_busy),
    .done(prog_done)
  );

endmodule // data_eeprom_access_ctrl
`default_nettype wire

// [testbench/nvm_access_props.sv]
// port assertions for the nvm access controller
`timescale 1ns/10ps
`default_nettype none
module nvm_access_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire nvm_pkg::reg_sel_e reg_sel,
  input wire logic [7:0] pointer_low_byte,
  input wire logic [7:0] pointer_bank_byte,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic nvm_irq_enable,
  input wire logic mf_irq_enable,
  input wire logic global_irq_enable,
  input wire logic nvm_irq_flag_clr,
  input wire logic mf_irq_service,
  input wire logic nvm_irq_flag,
  input wire logic mf_irq_flag,
  input wire logic irq_req
);
  import nvm_pkg::*;
  // ----------
  // properties
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire ptr_ok = pointer_low_byte == 8'h40 && pointer_bank_byte == 8'h01;
  chk_ctrl_upper_zero: assert property (reg_sel == sel_ctrl
    |-> reg_rdata[7:4] == 4'h0) else $error("ctrl upper bits set");
  chk_index_upper_zero: assert property (reg_sel == sel_index
    |-> reg_rdata[7:6] == 2'h0) else $error("index upper bits set");
  chk_bank_hides_ctrl: assert property (reg_sel == sel_ctrl
    && !ptr_ok |-> reg_rdata == 8'h00) else $error("ctrl seen off bank");
  chk_index_write: assert property (reg_wr && reg_sel == sel_index
    ##1 reg_sel == sel_index |-> reg_rdata == ($past(reg_wdata) & 8'h3f))
    else $error("index write lost");
  chk_value_write: assert property (reg_wr && reg_sel == sel_value
    ##1 reg_sel == sel_value |-> reg_rdata == $past(reg_wdata))
    else $error("value write lost");
  chk_irq_req_and: assert property (irq_req == (nvm_irq_flag
    && mf_irq_flag && nvm_irq_enable && mf_irq_enable && global_irq_enable))
    else $error("irq request mismatch");
  chk_flag_pair_set: assert property ($rose(nvm_irq_flag)
    |-> mf_irq_flag) else $error("flags not set together");
  chk_nvm_flag_sticky: assert property (nvm_irq_flag
    && !nvm_irq_flag_clr |=> nvm_irq_flag) else $error("irq flag dropped");
  cover property (irq_req);
  cover property (nvm_irq_flag && mf_irq_service);
  cover property (reg_sel == sel_ctrl && ptr_ok && reg_rdata[0]);
endmodule // nvm_access_props
bind data_eeprom_access_ctrl nvm_access_props i_props (
  .core_clk(core_clk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .pointer_low_byte(pointer_low_byte), .pointer_bank_byte(pointer_bank_byte),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .nvm_irq_enable(nvm_irq_enable), .mf_irq_enable(mf_irq_enable),
  .global_irq_enable(global_irq_enable), .irq_req(irq_req),
  .nvm_irq_flag_clr(nvm_irq_flag_clr), .mf_irq_service(mf_irq_service),
  .nvm_irq_flag(nvm_irq_flag), .mf_irq_flag(mf_irq_flag));
`default_nettype wire

// [testbench/data_eeprom_access_ctrl_tb_top.sv]
// register-level bench for the nvm access controller
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_access_ctrl_tb_top;
  import nvm_pkg::*;
  // -------------------
  // stimulus and checks
  // -------------------
  logic core_clk, rst, reg_wr, nvm_irq_enable, mf_irq_enable, irq_req;
  logic global_irq_enable, nvm_irq_flag_clr, mf_irq_service;
  logic nvm_irq_flag, mf_irq_flag;
  reg_sel_e reg_sel;
  logic [7:0] pointer_low_byte, pointer_bank_byte, reg_wdata, reg_rdata, rv;
  int err_count, samples_checked, n;
  data_eeprom_access_ctrl i_dut (.core_clk(core_clk), .rst(rst),
    .reg_sel(reg_sel), .pointer_low_byte(pointer_low_byte),
    .pointer_bank_byte(pointer_bank_byte), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nvm_irq_enable(nvm_irq_enable), .mf_irq_enable(mf_irq_enable),
    .global_irq_enable(global_irq_enable), .irq_req(irq_req),
    .nvm_irq_flag_clr(nvm_irq_flag_clr), .mf_irq_service(mf_irq_service),
    .nvm_irq_flag(nvm_irq_flag), .mf_irq_flag(mf_irq_flag));
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(reg_sel_e sel, logic [7:0] d);
    @(posedge core_clk);
    reg_sel <= sel;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(reg_sel_e sel);
    @(posedge core_clk);
    reg_sel <= sel;
    @(negedge core_clk);
    rv = reg_rdata;
  endtask
  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #60000;
    err_count++;
    complete_run;
  end
  initial
  begin
    {rst, nvm_irq_enable, mf_irq_enable, global_irq_enable} = 4'hf;
    {reg_wr, nvm_irq_flag_clr, mf_irq_service} = 3'h0;
    reg_sel = sel_none;
    reg_wdata = 8'h00;
    pointer_low_byte = 8'h40;
    pointer_bank_byte = 8'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    rd(sel_index);
    chk("index", rv, 8'h00);
    rd(sel_value);
    chk("value", rv, 8'h00);
    wr(sel_ctrl, 8'h0a);
    pointer_bank_byte <= 8'h01;
    rd(sel_ctrl);
    chk("ctrl", rv, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(sel_ctrl, 8'h03 << (2 * i));
      rd(sel_ctrl);
      chk("ctrl", rv, 8'h02 << (2 * i));
    end
    wr(sel_index, 8'hff);
    rd(sel_index);
    chk("index", rv, 8'h3f);
    wr(sel_value, 8'hc3);
    global_irq_enable <= 1'h0;
    wr(sel_ctrl, 8'h08);
    wr(sel_ctrl, 8'h0c);
    global_irq_enable <= 1'h1;
    rd(sel_ctrl);
    chk("ctrl", rv, 8'h0c);
    n = 0;
    while (rv[2] === 1'h1 && n < 400)
    begin
      rd(sel_ctrl);
      n++;
    end
    chk("ctrl", rv, 8'h08);
    repeat (2) @(negedge core_clk);
    chk("flags", {5'h00, mf_irq_flag, nvm_irq_flag, irq_req}, 8'h07);
    @(posedge core_clk);
    global_irq_enable <= 1'h0;
    @(negedge core_clk);
    chk("flags", {5'h00, mf_irq_flag, nvm_irq_flag, irq_req}, 8'h06);
    @(posedge core_clk);
    global_irq_enable <= 1'h1;
    mf_irq_service <= 1'h1;
    @(posedge core_clk);
    mf_irq_service <= 1'h0;
    @(negedge core_clk);
    chk("flags", {5'h00, mf_irq_flag, nvm_irq_flag, irq_req}, 8'h02);
    @(posedge core_clk);
    nvm_irq_flag_clr <= 1'h1;
    @(posedge core_clk);
    nvm_irq_flag_clr <= 1'h0;
    wr(sel_value, 8'h00);
    wr(sel_ctrl, 8'h02);
    wr(sel_ctrl, 8'h03);
    rd(sel_value);
    chk("value", rv, 8'h00);
    rd(sel_ctrl);
    n = 0;
    while (rv[0] === 1'h1 && n < 50)
    begin
      rd(sel_ctrl);
      n++;
    end
    chk("ctrl", rv, 8'h02);
    repeat (5) rd(sel_value);
    chk("value", rv, 8'hc3);
    chk("flags", {6'h00, mf_irq_flag, nvm_irq_flag}, 8'h00);
    @(posedge core_clk);
    rst <= 1'h1;
    @(posedge core_clk);
    rst <= 1'h0;
    rd(sel_ctrl);
    chk("ctrl", rv, 8'h00);
    rd(sel_value);
    chk("value", rv, 8'h00);
    complete_run;
  end
endmodule // data_eeprom_access_ctrl_tb_top
`default_nettype wire
